// ### sfic_pkg.sv
`default_nettype none
// ----------------------------------------------------------------
// Sample FIFO constants
// ----------------------------------------------------------------
package sfic_pkg;
    // Buffer shape
    localparam int unsigned SFIC_DEPTH = 128;
    localparam int unsigned SFIC_AW = 7;
    localparam int unsigned SFIC_DW = 8;
    localparam logic [7:0] SFIC_FULL_COUNT = 8'h80;
    localparam logic [6:0] SFIC_LOST_MAX = 7'h7f;

    // Register offsets
    localparam logic [7:0] SFIC_ADDR_IEN1 = 8'h02;
    localparam logic [7:0] SFIC_ADDR_IEN2 = 8'h03;
    localparam logic [7:0] SFIC_ADDR_WPTR = 8'h04;
    localparam logic [7:0] SFIC_ADDR_RPTR = 8'h05;
    localparam logic [7:0] SFIC_ADDR_LOST = 8'h06;
    localparam logic [7:0] SFIC_ADDR_CNT = 8'h07;
    localparam logic [7:0] SFIC_ADDR_DATA = 8'h08;
    localparam logic [7:0] SFIC_ADDR_CFG1 = 8'h09;
    localparam logic [7:0] SFIC_ADDR_CFG2 = 8'h0a;

    // Field positions
    localparam int unsigned SFIC_IEN1_AFULL = 7;
    localparam int unsigned SFIC_IEN1_DRDY = 6;
    localparam int unsigned SFIC_IEN1_TEMP = 2;
    localparam int unsigned SFIC_IEN1_SUPPLY = 1;
    localparam int unsigned SFIC_IEN2_AUTH = 0;
    localparam int unsigned SFIC_CFG2_FLUSH = 4;
    localparam int unsigned SFIC_CFG2_CLRSEL = 3;
    localparam int unsigned SFIC_CFG2_AFTYPE = 2;
    localparam int unsigned SFIC_CFG2_ROLL = 1;

    // Reset values
    localparam logic [7:1] SFIC_IEN1_RST = 7'h00;
    localparam logic SFIC_IEN2_RST = 1'b0;
    localparam logic [6:0] SFIC_CFG1_RST = 7'h3f;
    localparam logic [3:1] SFIC_CFG2_RST = 3'h0;
endpackage : sfic_pkg
`default_nettype wire

// ### sfic_mem_if.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Storage port between controller and sample array
// ----------------------------------------------------------------
interface sfic_mem_if;
    logic wr_en;
    logic [6:0] wr_idx;
    logic [7:0] wr_data;
    logic [6:0] rd_idx;
    logic [7:0] rd_data;
    modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
    modport store (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : sfic_mem_if
`default_nettype wire

// ### sfic_mem.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Sample array, flip-flop storage
// ----------------------------------------------------------------
module sfic_mem
    import sfic_pkg::*;
(
    input wire logic clk,
    sfic_mem_if.store mem
);
    logic [SFIC_DW-1:0] slot_q [SFIC_DEPTH];

    // No reset: contents are only meaningful once counted
    always_ff @(posedge clk) begin
        if (mem.wr_en) begin
            slot_q[mem.wr_idx] <= mem.wr_data;
        end
    end

    // Read side is a plain index; caller registers the result
    assign mem.rd_data = slot_q[mem.rd_idx];
endmodule : sfic_mem
`default_nettype wire

// ### sfic_top.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Sample FIFO with interrupt control
// ----------------------------------------------------------------
// Overview of operation
// RULE1: Write pointer advances on each push
// RULE2: Read pointer advances on each pop
// RULE3: Host may rewrite read pointer to reread
// RULE4: Host avoids rewriting pointer into almost-full
// RULE5: Saturating count of lost samples when full
// RULE6: Item count up on push, down on read
// RULE7: Data register read pops one item
// RULE8: Almost-full when free slots equal threshold
// RULE9: Flush zeros pointers and count, self-clears
// RULE10: Clear-select adds data read as clear
// RULE11: Repeat style re-raises on every sample
// RULE12: Once style raises only on fresh entry
// RULE13: Roll-over overwrites oldest, both pointers advance
// RULE14: Stop-on-full drops sample, pointer holds
// RULE15: Proximity mode always pushes
// RULE16: Temperature interrupt gated by its enable
// RULE17: Supply interrupt gated by its enable
// RULE18: Second enable bit 0 gates authentication
// RULE19: Almost-full gated by enable bit 7
// RULE20: Empty data read leaves pointer, count
// RULE21: Pointers wrap from 127 to 0
module sfic_top
    import sfic_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic status_rd,
    input wire logic sample_valid,
    input wire logic [7:0] sample_data,
    input wire logic prox_mode,
    input wire logic temp_ready,
    input wire logic supply_oor,
    input wire logic auth_done,
    output logic afull_irq,
    output logic data_ready_irq,
    output logic temp_irq,
    output logic supply_irq,
    output logic auth_irq
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // 7-bit add wraps 127 to 0 for free
    function automatic logic [6:0] ptr_inc(input logic [6:0] p);
        ptr_inc = p + 7'h01;
    endfunction : ptr_inc

    function automatic logic [6:0] sat_inc(input logic [6:0] v);
        sat_inc = (v == SFIC_LOST_MAX) ? v : v + 7'h01;
    endfunction : sat_inc

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [6:0] write_pointer_q, write_pointer_d;
    logic [6:0] read_pointer_q, read_pointer_d;
    logic [7:0] cnt_q, cnt_d;
    logic [6:0] lost_sample_count_q;
    logic [7:1] ien1_q;
    logic ien2_q;
    logic [6:0] thr_q;
    logic [3:1] cfg2_q;
    logic afull_q, drdy_q, afull_cond_q;
    logic [7:0] rdata_q;

    logic full, empty, rd_data_hit, pop, flush, rptr_wr;
    logic push_ok, overwrite, lost, afull_cond_d, set_af, clr_flags;
    logic roll_over_on_full, clear_on_data_read, af_once;
    logic [7:0] free_d;

    sfic_mem_if mem_if ();

    sfic_mem u_mem (
        .clk(clk),
        .mem(mem_if.store)
    );

    assign roll_over_on_full = cfg2_q[SFIC_CFG2_ROLL];
    assign clear_on_data_read = cfg2_q[SFIC_CFG2_CLRSEL];
    assign af_once = cfg2_q[SFIC_CFG2_AFTYPE];

    // ------------------------------------------------------------
    // Access decode and push policy
    // ------------------------------------------------------------
    assign full = (cnt_q == SFIC_FULL_COUNT);
    assign empty = (cnt_q == 8'h00);
    assign rd_data_hit = reg_rd && (reg_addr == SFIC_ADDR_DATA);
    assign pop = rd_data_hit && !empty; // RULE7 RULE20
    assign flush = reg_wr && (reg_addr == SFIC_ADDR_CFG2) && reg_wdata[SFIC_CFG2_FLUSH]; // RULE9
    assign rptr_wr = reg_wr && (reg_addr == SFIC_ADDR_RPTR); // RULE3
    // A pop in the same cycle frees a slot, so no loss then
    assign push_ok = sample_valid && !flush
        && (!full || pop || roll_over_on_full || prox_mode); // RULE13 RULE14 RULE15
    assign overwrite = push_ok && full && !pop; // RULE13
    assign lost = sample_valid && !flush && full && !pop; // RULE5

    // Storage write and read port
    assign mem_if.wr_en = push_ok;
    assign mem_if.wr_idx = write_pointer_q;
    assign mem_if.wr_data = sample_data;
    assign mem_if.rd_idx = read_pointer_q;

    // ------------------------------------------------------------
    // Pointers and item count
    // ------------------------------------------------------------
    always_comb begin
        write_pointer_d = write_pointer_q;
        if (flush) begin
            write_pointer_d = 7'h00; // RULE9
        end else if (push_ok) begin
            write_pointer_d = ptr_inc(write_pointer_q); // RULE1 RULE21
        end
    end

    always_comb begin
        read_pointer_d = read_pointer_q;
        if (flush) begin
            read_pointer_d = 7'h00; // RULE9
        end else if (rptr_wr) begin
            read_pointer_d = reg_wdata[6:0]; // RULE3
        end else if (pop || overwrite) begin
            read_pointer_d = ptr_inc(read_pointer_q); // RULE2 RULE13 RULE21
        end
    end

    // Pointer rewrite recomputes the backlog; equal pointers read as empty
    always_comb begin
        cnt_d = cnt_q;
        if (flush) begin
            cnt_d = 8'h00; // RULE9
        end else if (rptr_wr) begin
            cnt_d = {1'b0, write_pointer_d - reg_wdata[6:0]}; // RULE3
        end else if (push_ok && !overwrite && !pop) begin
            cnt_d = cnt_q + 8'h01; // RULE6
        end else if (pop && !push_ok) begin
            cnt_d = cnt_q - 8'h01; // RULE6
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            write_pointer_q <= 7'h00;
            read_pointer_q <= 7'h00;
            cnt_q <= 8'h00;
        end else begin
            write_pointer_q <= write_pointer_d;
            read_pointer_q <= read_pointer_d;
            cnt_q <= cnt_d;
        end
    end

    // Lost samples survive a flush so software can still see them
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lost_sample_count_q <= 7'h00;
        end else if (lost) begin
            lost_sample_count_q <= sat_inc(lost_sample_count_q); // RULE5
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ien1_q <= SFIC_IEN1_RST;
            ien2_q <= SFIC_IEN2_RST;
            thr_q <= SFIC_CFG1_RST;
            cfg2_q <= SFIC_CFG2_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                SFIC_ADDR_IEN1: ien1_q <= reg_wdata[7:1];
                SFIC_ADDR_IEN2: ien2_q <= reg_wdata[SFIC_IEN2_AUTH]; // RULE18
                SFIC_ADDR_CFG1: thr_q <= reg_wdata[6:0];
                SFIC_ADDR_CFG2: cfg2_q <= reg_wdata[3:1]; // Flush bit is not stored
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Almost-full and data-ready flags
    // ------------------------------------------------------------
    // Condition judged on the count after this cycle's update
    assign free_d = SFIC_FULL_COUNT - cnt_d;
    assign afull_cond_d = (free_d == {1'b0, thr_q}); // RULE8
    // Once style needs an edge of the condition, repeat style any push
    assign set_af = push_ok && afull_cond_d && (!af_once || !afull_cond_q); // RULE11 RULE12
    assign clr_flags = status_rd || (clear_on_data_read && rd_data_hit); // RULE10

    // Set beats clear so an event in the clearing cycle survives
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            afull_q <= 1'b0;
            drdy_q <= 1'b0;
            afull_cond_q <= 1'b0;
        end else begin
            afull_cond_q <= afull_cond_d;
            if (set_af) begin
                afull_q <= 1'b1; // RULE11 RULE12
            end else if (clr_flags) begin
                afull_q <= 1'b0; // RULE10
            end
            if (push_ok) begin
                drdy_q <= 1'b1;
            end else if (clr_flags) begin
                drdy_q <= 1'b0; // RULE10
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt gating
    // ------------------------------------------------------------
    assign afull_irq = afull_q && ien1_q[SFIC_IEN1_AFULL]; // RULE19
    assign data_ready_irq = drdy_q && ien1_q[SFIC_IEN1_DRDY];
    assign temp_irq = temp_ready && ien1_q[SFIC_IEN1_TEMP]; // RULE16
    assign supply_irq = supply_oor && ien1_q[SFIC_IEN1_SUPPLY]; // RULE17
    assign auth_irq = auth_done && ien2_q; // RULE18

    // ------------------------------------------------------------
    // Read-back
    // ------------------------------------------------------------
    // Unmapped offsets and reserved bits read as zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                SFIC_ADDR_IEN1: rdata_q <= {ien1_q, 1'b0};
                SFIC_ADDR_IEN2: rdata_q <= {7'h00, ien2_q};
                SFIC_ADDR_WPTR: rdata_q <= {1'b0, write_pointer_q};
                SFIC_ADDR_RPTR: rdata_q <= {1'b0, read_pointer_q};
                SFIC_ADDR_LOST: rdata_q <= {1'b0, lost_sample_count_q};
                SFIC_ADDR_CNT: rdata_q <= cnt_q;
                SFIC_ADDR_DATA: rdata_q <= mem_if.rd_data; // RULE7
                SFIC_ADDR_CFG1: rdata_q <= {1'b0, thr_q};
                SFIC_ADDR_CFG2: rdata_q <= {4'h0, cfg2_q, 1'b0};
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_flush;
        flush;
    endsequence

    sequence s_plain_push;
        push_ok && !overwrite && !pop && !rptr_wr;
    endsequence

    sequence s_zeroed;
        write_pointer_q == 7'h00 && read_pointer_q == 7'h00 && cnt_q == 8'h00;
    endsequence

    a_wptr_advance: assert property ( // RULE1
        push_ok |=> write_pointer_q == $past(write_pointer_q) + 7'h01)
        else $error("write pointer did not advance on push");

    a_rptr_pop: assert property ( // RULE2
        pop |=> read_pointer_q == $past(read_pointer_q) + 7'h01)
        else $error("read pointer did not advance on pop");

    a_rptr_write: assert property ( // RULE3
        rptr_wr && !flush |=> read_pointer_q == $past(reg_wdata[6:0]))
        else $error("read pointer write not taken");

    a_lost_count: assert property ( // RULE5
        lost && lost_sample_count_q != SFIC_LOST_MAX
        |=> lost_sample_count_q == $past(lost_sample_count_q) + 7'h01)
        else $error("lost sample not counted");

    a_lost_saturate: assert property ( // RULE5
        lost_sample_count_q == SFIC_LOST_MAX |=> lost_sample_count_q == SFIC_LOST_MAX)
        else $error("lost counter left saturation");

    a_count_push: assert property ( // RULE6
        s_plain_push |=> cnt_q == $past(cnt_q) + 8'h01)
        else $error("item count did not rise on push");

    a_count_pop: assert property ( // RULE6
        pop && !sample_valid |=> cnt_q == $past(cnt_q) - 8'h01)
        else $error("item count did not fall on read");

    a_flush_zero: assert property ( // RULE9
        s_flush |=> s_zeroed ##0 cfg2_q == $past(reg_wdata[3:1]))
        else $error("flush did not zero the buffer");

    a_status_clear: assert property ( // RULE10
        status_rd && !set_af |=> !afull_q)
        else $error("status read did not clear almost-full");

    a_data_noclear: assert property ( // RULE10
        afull_q && rd_data_hit && !clear_on_data_read && !status_rd |=> afull_q)
        else $error("data read cleared almost-full");

    a_afull_repeat: assert property ( // RULE11
        push_ok && !af_once && afull_cond_d |=> afull_q ##0 afull_cond_q)
        else $error("repeat style did not re-raise");

    a_afull_once: assert property ( // RULE12
        af_once && afull_cond_q && !afull_q |=> !afull_q)
        else $error("once style re-raised without fresh event");

    a_afull_level: assert property ( // RULE8
        afull_cond_q |-> (SFIC_FULL_COUNT - cnt_q) == {1'b0, $past(thr_q)})
        else $error("almost-full condition wrong");

    a_roll_over: assert property ( // RULE13
        overwrite && !rptr_wr |=> cnt_q == SFIC_FULL_COUNT
        && read_pointer_q == $past(read_pointer_q) + 7'h01)
        else $error("roll-over did not advance read pointer");

    a_stop_full: assert property ( // RULE14
        sample_valid && full && !pop && !roll_over_on_full && !prox_mode && !flush
        |=> $stable(write_pointer_q))
        else $error("stop-on-full moved write pointer");

    a_prox_push: assert property ( // RULE15
        sample_valid && prox_mode && !flush |=> write_pointer_q == $past(write_pointer_q) + 7'h01)
        else $error("proximity sample not pushed");

    a_irq_gate: assert property ( // RULE16 RULE17 RULE18 RULE19
        (temp_irq |-> ien1_q[SFIC_IEN1_TEMP]) and (supply_irq |-> ien1_q[SFIC_IEN1_SUPPLY])
        and (auth_irq |-> ien2_q) and (afull_irq |-> ien1_q[SFIC_IEN1_AFULL]))
        else $error("interrupt passed a cleared enable");

    a_empty_read: assert property ( // RULE20
        rd_data_hit && empty && !sample_valid |=> $stable(read_pointer_q) && cnt_q == 8'h00)
        else $error("empty read moved the buffer");
endmodule : sfic_top
`default_nettype wire

// ### sfic_host.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Host processor on the register strobes
// ----------------------------------------------------------------
module sfic_host (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic status_rd
);
    // Quiet bus at time zero
    initial begin
        reg_addr = 8'h5a;
        reg_wdata = 8'ha5;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        status_rd = 1'b0;
    end

    // One strobe per access; lines scrambled once released, so stale values never pass
    task automatic access(input logic [7:0] a, input logic [7:0] d, input logic wr);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = wr;
        reg_rd = !wr;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : access

    // Status register read done elsewhere in the device
    task automatic status_read();
        @(posedge clk);
        #1;
        status_rd = 1'b1;
        @(posedge clk);
        #1;
        status_rd = 1'b0;
    endtask : status_read

    // Rewind for a reread, refused if it would leave the buffer almost full
    task automatic rewind(input logic [6:0] p, input logic [6:0] wp, input logic [6:0] thr);
        if ({1'b0, 7'(wp - p)} + {1'b0, thr} < 8'h80) begin
            access(8'h05, {1'b0, p}, 1'b1);
        end
    endtask : rewind
endmodule : sfic_host
`default_nettype wire

// ### sfic_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module sfic_top_tb_top
    import sfic_pkg::*;
;
    logic clk, rst_n, sample_valid, prox_mode, temp_ready, supply_oor, auth_done;
    logic [7:0] sample_data, reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, status_rd, afull_irq, data_ready_irq, temp_irq, supply_irq, auth_irq;
    int fails, compares;
    logic [7:0] exp_q [$];
    // Reference buffer state
    logic [7:0] mem [128];
    logic [6:0] wp, rp, lost;
    logic [7:0] cnt;
    logic roll;

    sfic_top i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .status_rd(status_rd),
        .sample_valid(sample_valid), .sample_data(sample_data), .prox_mode(prox_mode),
        .temp_ready(temp_ready), .supply_oor(supply_oor), .auth_done(auth_done),
        .afull_irq(afull_irq), .data_ready_irq(data_ready_irq), .temp_irq(temp_irq),
        .supply_irq(supply_irq), .auth_irq(auth_irq));
    sfic_host i_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .status_rd(status_rd));

    always #4 clk = ~clk;

    // ----------------------------------------------------------------
    // Checking
    // ----------------------------------------------------------------
    task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_reg

    task automatic cmp_irq(input logic got, input logic exp);
        cmp_reg({7'h00, got}, {7'h00, exp});
    endtask : cmp_irq

    // Read data lands one cycle after the strobe edge
    always @(posedge clk) begin
        if (reg_rd === 1'b1) begin
            #2;
            cmp_reg(reg_rdata, exp_q.pop_front());
        end
    end

    task automatic end_sim();
        if (exp_q.size() != 0) fails++;
        if (fails == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    // ----------------------------------------------------------------
    // Stimulus helpers
    // ----------------------------------------------------------------
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_host.access(a, 8'h00, 1'b0);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.access(a, d, 1'b1);
    endtask : wr

    // Pop via the data port; empty reads return the slot under the pointer
    task automatic pop();
        rd(SFIC_ADDR_DATA, mem[rp]);
        if (cnt != 8'h00) begin
            rp++;
            cnt--;
        end
    endtask : pop

    // Back-to-back samples; a full buffer overwrites only in roll-over or proximity
    task automatic push(input int n);
        logic [7:0] d;
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            @(posedge clk);
            #1;
            sample_valid = 1'b1;
            sample_data = d;
            if (cnt == SFIC_FULL_COUNT && lost != SFIC_LOST_MAX) lost++;
            if (cnt != SFIC_FULL_COUNT || roll || prox_mode) begin
                if (cnt == SFIC_FULL_COUNT) rp++;
                else cnt++;
                mem[wp] = d;
                wp++;
            end
        end
        @(posedge clk);
        #1;
        sample_valid = 1'b0;
        sample_data = ~d;
    endtask : push

    // Hang guard
    initial begin
        for (int i = 0; i < 20000; i++) @(posedge clk);
        fails++;
        end_sim();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        sample_valid = 1'b0;
        sample_data = 8'h00;
        prox_mode = 1'b0;
        temp_ready = 1'b1;
        supply_oor = 1'b1;
        auth_done = 1'b1;
        fails = 0;
        compares = 0;
        {wp, rp, lost, cnt, roll} = '0;
        void'($urandom(32'hc3dc));
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        // Reset values, sources high but every enable clear
        cmp_reg({3'h0, afull_irq, data_ready_irq, temp_irq, supply_irq, auth_irq}, 8'h00);
        for (int a = 0; a < 16; a++) begin
            if (a != 8) rd(8'(a), (8'(a) == SFIC_ADDR_CFG1) ? 8'h3f : 8'h00);
        end
        wr(SFIC_ADDR_WPTR, 8'hff);
        wr(SFIC_ADDR_IEN2, 8'hff);
        rd(SFIC_ADDR_WPTR, 8'h00);
        rd(SFIC_ADDR_IEN2, 8'h01);
        // Roll-over, repeat style, threshold 0 means completely full
        wr(SFIC_ADDR_IEN1, 8'hc0);
        wr(SFIC_ADDR_CFG1, 8'h00);
        wr(SFIC_ADDR_CFG2, 8'h02);
        roll = 1'b1;
        push(127);
        cmp_irq(afull_irq, 1'b0);
        cmp_irq(data_ready_irq, 1'b1);
        push(1);
        cmp_irq(afull_irq, 1'b1);
        rd(SFIC_ADDR_WPTR, {1'b0, wp});
        rd(SFIC_ADDR_CNT, cnt);
        wr(SFIC_ADDR_IEN1, 8'h40);
        cmp_irq(afull_irq, 1'b0);
        wr(SFIC_ADDR_IEN1, 8'hc0);
        cmp_irq(afull_irq, 1'b1);
        i_host.status_read();
        cmp_irq(afull_irq, 1'b0);
        cmp_irq(data_ready_irq, 1'b0);
        push(3);
        cmp_irq(afull_irq, 1'b1);
        rd(SFIC_ADDR_WPTR, {1'b0, wp});
        rd(SFIC_ADDR_RPTR, {1'b0, rp});
        rd(SFIC_ADDR_LOST, {1'b0, lost});
        // Once style stays quiet while the condition persists
        wr(SFIC_ADDR_CFG2, 8'h06);
        i_host.status_read();
        push(1);
        cmp_irq(afull_irq, 1'b0);
        // Stop on full, then proximity, then saturation of lost count
        wr(SFIC_ADDR_CFG2, 8'h04);
        roll = 1'b0;
        push(2);
        rd(SFIC_ADDR_WPTR, {1'b0, wp});
        prox_mode = 1'b1;
        push(1);
        rd(SFIC_ADDR_WPTR, {1'b0, wp});
        prox_mode = 1'b0;
        push(125);
        rd(SFIC_ADDR_LOST, {1'b0, lost});
        // Clear select, then drain, then an empty read
        wr(SFIC_ADDR_CFG2, 8'h00);
        pop();
        cmp_irq(data_ready_irq, 1'b1);
        wr(SFIC_ADDR_CFG2, 8'h08);
        pop();
        cmp_irq(data_ready_irq, 1'b0);
        rd(SFIC_ADDR_CNT, cnt);
        for (int i = 0; i < 126; i++) pop();
        rd(SFIC_ADDR_RPTR, {1'b0, rp});
        pop();
        rd(SFIC_ADDR_RPTR, {1'b0, rp});
        rd(SFIC_ADDR_CNT, 8'h00);
        // Rewind two slots and fetch them again
        i_host.rewind(wp - 7'h02, wp, 7'h00);
        rp = wp - 7'h02;
        cnt = 8'h02;
        rd(SFIC_ADDR_CNT, cnt);
        pop();
        pop();
        // Flush zeroes pointers and count, control reads back clear
        push(5);
        wr(SFIC_ADDR_CFG2, 8'h10);
        {wp, rp, cnt} = '0;
        rd(SFIC_ADDR_WPTR, 8'h00);
        rd(SFIC_ADDR_RPTR, 8'h00);
        rd(SFIC_ADDR_CNT, 8'h00);
        rd(SFIC_ADDR_CFG2, 8'h00);
        // Threshold 126 free slots means two items; once style must still raise on entry
        wr(SFIC_ADDR_CFG2, 8'h04);
        wr(SFIC_ADDR_CFG1, 8'h7e);
        rd(SFIC_ADDR_CFG1, 8'h7e);
        push(1);
        cmp_irq(afull_irq, 1'b0);
        push(1);
        cmp_irq(afull_irq, 1'b1);
        // One interrupt source enabled at a time
        for (int i = 0; i < 3; i++) begin
            wr(SFIC_ADDR_IEN1, {5'h00, 3'(3'h4 >> i)});
            wr(SFIC_ADDR_IEN2, {7'h00, i == 2});
            cmp_reg({5'h00, temp_irq, supply_irq, auth_irq}, 8'(3'h4 >> i));
        end
        // Mid-run reset; the lost counter only ever returns to zero here
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        rd(SFIC_ADDR_LOST, 8'h00);
        rd(SFIC_ADDR_CFG1, 8'h3f);
        repeat (2) @(posedge clk);
        end_sim();
    end
endmodule : sfic_top_tb_top
`default_nettype wire
